//--- ati_cal_model.sv
// Model of the power-up self-calibration source feeding the bank.
// Assumes the bench clock; words stay steady so a soft reset reloads them.
`timescale 1ns/1ps
module ati_cal_model
    import ati_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          nrst,
    output logic               cal_valid,
    output ati_trim_type [1:0] cal_trim
);
    logic [2:0] cnt;

    assign cal_trim[0] = '{8'h11, 8'h22, 4'h3, 8'h44, 8'h55};
    assign cal_trim[1] = '{8'h99, 8'hAA, 4'hC, 8'hBB, 8'hCC};

    // One load pulse shortly after power-up
    always_ff @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt       <= 3'h0;
            cal_valid <= 1'b0;
        end else begin
            if (cnt != 3'h7) cnt <= cnt + 3'h1;
            cal_valid <= (cnt == 3'h5);
        end
    end
endmodule : ati_cal_model

//--- ati_pkg.sv
// Package for the converter trim and interleave corrector register bank.
// Assumes one clock domain; register requests arrive already deserialised.
package ati_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ATI_ADDR_PORT_CFG  = 8'h00;
    localparam logic [7:0] ATI_ADDR_INDEX     = 8'h10;
    localparam logic [7:0] ATI_ADDR_OFS_BIG   = 8'h20;
    localparam logic [7:0] ATI_ADDR_OFS_SMALL = 8'h21;
    localparam logic [7:0] ATI_ADDR_GAIN_BIG  = 8'h22;
    localparam logic [7:0] ATI_ADDR_GAIN_MID  = 8'h23;
    localparam logic [7:0] ATI_ADDR_GAIN_SML  = 8'h24;
    localparam logic [7:0] ATI_ADDR_PD_SEL    = 8'h25;
    localparam logic [7:0] ATI_ADDR_STATUS    = 8'h30;
    localparam logic [7:0] ATI_ADDR_RUN_CTRL  = 8'h31;
    localparam logic [7:0] ATI_ADDR_STAT_CTRL = 8'h32;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ATI_SOFT_RST_BIT = 5;
    localparam int ATI_RUN_ON_BIT   = 0;
    localparam int ATI_FREEZE_BIT   = 1;
    localparam int ATI_DIS_OFS_BIT  = 2;
    localparam int ATI_DIS_GAIN_BIT = 3;
    localparam int ATI_DIS_SKEW_BIT = 4;
    localparam int ATI_NOTCH_BIT    = 5;
    localparam int ATI_ST_LOWPWR    = 0;
    localparam int ATI_ST_LOWAC     = 1;
    localparam int ATI_ST_SETTLED   = 2;
    localparam int ATI_SKIP_BIT     = 5;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] ATI_PORT_CFG_RST  = 8'h18;
    localparam logic [7:0] ATI_PORT_CFG_MASK = 8'hDF;
    localparam logic [1:0] ATI_INDEX_RST     = 2'h0;
    localparam logic [2:0] ATI_PD_SEL_RST    = 3'h0;
    localparam logic [7:0] ATI_RUN_RST       = 8'h00;
    localparam logic [7:0] ATI_STAT_CTRL_RST = 8'h00;
    localparam logic [7:0] ATI_BAD_INDEX     = 8'hAD;
    localparam logic [7:0] ATI_UNMAPPED      = 8'h00;
    localparam logic [1:0] ATI_IDX_CORE0     = 2'h1;
    localparam logic [1:0] ATI_IDX_CORE1     = 2'h2;
    localparam logic       ATI_REF_CORE      = 1'b0;

    localparam logic [2:0] ATI_PD_PIN    = 3'h0;
    localparam logic [2:0] ATI_PD_NORMAL = 3'h1;
    localparam logic [2:0] ATI_PD_NAP    = 3'h2;
    localparam logic [2:0] ATI_PD_SLEEP  = 3'h4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int ATI_SETTLE_MS     = 1000;
    localparam int ATI_CLK_KHZ       = 125000;
    localparam int ATI_SETTLE_CYCLES = ATI_SETTLE_MS * ATI_CLK_KHZ;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ATI_PM_NORMAL = 2'b00,
        ATI_PM_NAP    = 2'b01,
        ATI_PM_SLEEP  = 2'b10
    } ati_pmode_type;

    typedef enum logic [1:0] {
        ATI_CS_OFF    = 2'b00,
        ATI_CS_COARSE = 2'b01,
        ATI_CS_RUN    = 2'b10,
        ATI_CS_HOLD   = 2'b11
    } ati_corr_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ati_req_type;

    typedef struct packed {
        logic [7:0] ofs_big;
        logic [7:0] ofs_small;
        logic [3:0] gain_big;
        logic [7:0] gain_mid;
        logic [7:0] gain_small;
    } ati_trim_type;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Returns {valid, core} for the core-select field
    function automatic logic [1:0] ati_index_decode(input logic [1:0] idx);
        logic [1:0] res;
        res = 2'h0;
        if (idx == ATI_IDX_CORE0) res = 2'h2;
        if (idx == ATI_IDX_CORE1) res = 2'h3;
        return res;
    endfunction : ati_index_decode

    function automatic ati_pmode_type ati_pd_decode(input logic [2:0] code,
                                                    input ati_pmode_type pin);
        ati_pmode_type res;
        res = pin;
        case (code)
            ATI_PD_NORMAL: res = ATI_PM_NORMAL;
            ATI_PD_NAP:    res = ATI_PM_NAP;
            ATI_PD_SLEEP:  res = ATI_PM_SLEEP;
            default:       res = pin;
        endcase
        return res;
    endfunction : ati_pd_decode

endpackage : ati_pkg

//--- ati_pwr_sel.sv
// Power-down mode selector for one converter core.
// Assumes the mode pin level is already synchronous to clk.
`timescale 1ns/1ps
module ati_pwr_sel
    import ati_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [2:0]    code,
    input  wire ati_pmode_type pin,
    output ati_pmode_type      mode
);

    // ------------------------------------------------------------------
    // Register override or pin
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode <= ATI_PM_NORMAL;
        end else begin
            mode <= ati_pd_decode(code, pin);
        end
    end

endmodule : ati_pwr_sel

//--- ati_regs.sv
// Trim, power-down and interleave corrector register bank of a dual-core converter.
// Assumes a serial front end delivers one decoded request per cycle on req.
//
// Function
// - Coarse and fine offset words per core
// - Offset words are two's complement
// - Trims load self-calibration result after power-up
// - Coarse gain four bits, medium/fine eight
// - Coarse gain bits carry individual weights
// - Power-down field decodes pin/normal/nap/sleep
// - Pin global, register override per core
// - Soft reset leaves power-down register alone
// - Poor input holds corrector, freezes estimates
// - Status bit 0 shows low power
// - Status bit 1 shows low AC power
// - Status bit 2 shows settling complete
// - Control bit 0 turns corrector on
// - Control bit 1 freezes, resumes exactly
// - Control bits 2-4 disable individual adjustments
// - Control bit 5 selects notch filter
// - Static control takes effect at turn-on
// - Static bit 5 skips coarse adjustment
// - Preset reference gain: adjust other core only
// - Core-select field routes indexed accesses
// - Soft reset restores register defaults except power-down select
`timescale 1ns/1ps
module ati_regs
    import ati_pkg::*;
#(
    parameter int SETTLE_CYCLES = ATI_SETTLE_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire ati_req_type         req,
    output logic [7:0]               rdata,
    output logic                     rvalid,
    input  wire logic                cal_valid,
    input  wire ati_trim_type [1:0]  cal_trim,
    input  wire ati_pmode_type       power_mode_pin,
    input  wire logic                low_power_det,
    input  wire logic                low_ac_det,
    output ati_trim_type [1:0]       trim,
    output ati_pmode_type [1:0]      pmode,
    output logic                     corr_on,
    output logic                     corr_coarse_start,
    output logic                     corr_apply,
    output logic                     corr_upd_ofs,
    output logic                     corr_upd_gain,
    output logic                     corr_upd_skew,
    output logic                     notch_en,
    output logic                     gain_match_only
);

    logic [7:0]      port_cfg;
    logic [1:0]      dev_index;
    logic [2:0]      pd_sel [1:0];
    logic [7:0]      run_ctrl;
    logic [7:0]      stat_ctrl;
    logic [7:0]      stat_act;
    logic [7:0]      status;
    logic            ref_gain_set;
    logic            soft_rst;
    logic            idx_ok;
    logic            core;
    logic            is_indexed;
    logic            settled;
    logic            timer_clear;
    logic            timer_run;
    logic            freeze;
    ati_corr_type    cstate;
    ati_corr_type    next_cstate;

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    assign soft_rst = req.wr && req.addr == ATI_ADDR_PORT_CFG
                      && req.wdata[ATI_SOFT_RST_BIT];
    assign {idx_ok, core} = ati_index_decode(dev_index);
    assign is_indexed = req.addr inside {ATI_ADDR_OFS_BIG, ATI_ADDR_OFS_SMALL,
                                         ATI_ADDR_GAIN_BIG, ATI_ADDR_GAIN_MID,
                                         ATI_ADDR_GAIN_SML, ATI_ADDR_PD_SEL};
    assign freeze = run_ctrl[ATI_FREEZE_BIT];

    // ------------------------------------------------------------------
    // Port configuration and core select
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_cfg  <= ATI_PORT_CFG_RST;
            dev_index <= ATI_INDEX_RST;
        end else if (soft_rst) begin
            port_cfg  <= ATI_PORT_CFG_RST;
            dev_index <= ATI_INDEX_RST;
        end else if (req.wr) begin
            if (req.addr == ATI_ADDR_PORT_CFG) begin
                port_cfg <= req.wdata & ATI_PORT_CFG_MASK;
            end
            if (req.addr == ATI_ADDR_INDEX) begin
                dev_index <= req.wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Trim words
    // ------------------------------------------------------------------
    // Offset words are stored raw; the analog side treats them as
    // two's complement, gain codes as offset binary around 0x80.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trim <= '0;
        end else if (cal_valid || soft_rst) begin
            trim <= cal_trim;
        end else if (req.wr && idx_ok) begin
            case (req.addr)
                ATI_ADDR_OFS_BIG: begin
                    trim[core].ofs_big <= req.wdata;
                end
                ATI_ADDR_OFS_SMALL: begin
                    trim[core].ofs_small <= req.wdata;
                end
                ATI_ADDR_GAIN_BIG: begin
                    trim[core].gain_big <= req.wdata[3:0];
                end
                ATI_ADDR_GAIN_MID: begin
                    trim[core].gain_mid <= req.wdata;
                end
                ATI_ADDR_GAIN_SML: begin
                    trim[core].gain_small <= req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Power-down select
    // ------------------------------------------------------------------
    // Soft reset does not reach this register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pd_sel[0] <= ATI_PD_SEL_RST;
            pd_sel[1] <= ATI_PD_SEL_RST;
        end else if (req.wr && idx_ok && req.addr == ATI_ADDR_PD_SEL) begin
            pd_sel[core] <= req.wdata[2:0];
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_pwr
        ati_pwr_sel u_pwr_sel (
            .clk  (clk),
            .nrst (nrst),
            .code (pd_sel[g]),
            .pin  (power_mode_pin),
            .mode (pmode[g])
        );
    end

    // ------------------------------------------------------------------
    // Corrector control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_ctrl  <= ATI_RUN_RST;
            stat_ctrl <= ATI_STAT_CTRL_RST;
        end else if (soft_rst) begin
            run_ctrl  <= ATI_RUN_RST;
            stat_ctrl <= ATI_STAT_CTRL_RST;
        end else if (req.wr) begin
            if (req.addr == ATI_ADDR_RUN_CTRL) begin
                run_ctrl <= req.wdata;
            end
            if (req.addr == ATI_ADDR_STAT_CTRL) begin
                stat_ctrl <= req.wdata;
            end
        end
    end

    // Reference core gain programmed while the corrector is off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ref_gain_set <= 1'b0;
        end else if (soft_rst) begin
            ref_gain_set <= 1'b0;
        end else if (req.wr && idx_ok && core == ATI_REF_CORE
                     && cstate == ATI_CS_OFF
                     && (req.addr == ATI_ADDR_GAIN_MID
                         || req.addr == ATI_ADDR_GAIN_SML)) begin
            ref_gain_set <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Corrector state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_cstate = cstate;
        case (cstate)
            ATI_CS_OFF: begin
                if (run_ctrl[ATI_RUN_ON_BIT]) begin
                    next_cstate = stat_ctrl[ATI_SKIP_BIT] ? ATI_CS_RUN
                                                          : ATI_CS_COARSE;
                end
            end
            ATI_CS_COARSE: begin
                next_cstate = ATI_CS_RUN;
            end
            ATI_CS_RUN: begin
                if (low_power_det) begin
                    next_cstate = ATI_CS_HOLD;
                end
            end
            ATI_CS_HOLD: begin
                if (!low_power_det) begin
                    next_cstate = ATI_CS_RUN;
                end
            end
            default: begin
                next_cstate = ATI_CS_OFF;
            end
        endcase
        if (!run_ctrl[ATI_RUN_ON_BIT]) begin
            next_cstate = ATI_CS_OFF;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cstate <= ATI_CS_OFF;
        end else begin
            cstate <= next_cstate;
        end
    end

    // Static settings are captured only at turn-on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stat_act        <= ATI_STAT_CTRL_RST;
            gain_match_only <= 1'b0;
        end else if (cstate == ATI_CS_OFF && run_ctrl[ATI_RUN_ON_BIT]) begin
            stat_act        <= stat_ctrl;
            gain_match_only <= ref_gain_set;
        end
    end

    // ------------------------------------------------------------------
    // Settling
    // ------------------------------------------------------------------
    assign timer_clear = (cstate == ATI_CS_OFF);
    assign timer_run   = (cstate == ATI_CS_RUN) && !freeze;

    ati_settle_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .clk   (clk),
        .nrst  (nrst),
        .clear (timer_clear),
        .run   (timer_run),
        .done  (settled)
    );

    // ------------------------------------------------------------------
    // Corrector outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            corr_on           <= 1'b0;
            corr_coarse_start <= 1'b0;
            corr_apply        <= 1'b0;
            corr_upd_ofs      <= 1'b0;
            corr_upd_gain     <= 1'b0;
            corr_upd_skew     <= 1'b0;
            notch_en          <= 1'b0;
        end else begin
            corr_on           <= (next_cstate != ATI_CS_OFF);
            corr_coarse_start <= (next_cstate == ATI_CS_COARSE);
            corr_apply        <= (next_cstate == ATI_CS_RUN)
                                 || (next_cstate == ATI_CS_HOLD);
            corr_upd_ofs      <= (next_cstate == ATI_CS_RUN) && !freeze
                                 && !run_ctrl[ATI_DIS_OFS_BIT];
            corr_upd_gain     <= (next_cstate == ATI_CS_RUN) && !freeze
                                 && !run_ctrl[ATI_DIS_GAIN_BIT];
            corr_upd_skew     <= (next_cstate == ATI_CS_RUN) && !freeze
                                 && !run_ctrl[ATI_DIS_SKEW_BIT]
                                 && !low_ac_det;
            notch_en          <= run_ctrl[ATI_NOTCH_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status <= 8'h00;
        end else begin
            status                 <= 8'h00;
            status[ATI_ST_LOWPWR]  <= (cstate == ATI_CS_HOLD);
            status[ATI_ST_LOWAC]   <= (cstate != ATI_CS_OFF) && low_ac_det;
            status[ATI_ST_SETTLED] <= settled;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                if (is_indexed && !idx_ok) begin
                    rdata <= ATI_BAD_INDEX;
                end else begin
                    case (req.addr)
                        ATI_ADDR_PORT_CFG:  rdata <= port_cfg;
                        ATI_ADDR_INDEX:     rdata <= {6'h00, dev_index};
                        ATI_ADDR_OFS_BIG:   rdata <= trim[core].ofs_big;
                        ATI_ADDR_OFS_SMALL: rdata <= trim[core].ofs_small;
                        ATI_ADDR_GAIN_BIG:  rdata <= {4'h0, trim[core].gain_big};
                        ATI_ADDR_GAIN_MID:  rdata <= trim[core].gain_mid;
                        ATI_ADDR_GAIN_SML:  rdata <= trim[core].gain_small;
                        ATI_ADDR_PD_SEL:    rdata <= {5'h00, pd_sel[core]};
                        ATI_ADDR_STATUS:    rdata <= status;
                        ATI_ADDR_RUN_CTRL:  rdata <= run_ctrl;
                        ATI_ADDR_STAT_CTRL: rdata <= stat_ctrl;
                        default:            rdata <= ATI_UNMAPPED;
                    endcase
                end
            end
        end
    end

endmodule : ati_regs

//--- ati_regs_asserts.sv
// Port checker for the trim and interleave corrector register bank.
// Assumes one clock domain and the registered outputs of the bank.
`timescale 1ns/1ps
module ati_regs_asserts
    import ati_pkg::*;
#(
    parameter int SETTLE_CYCLES = ATI_SETTLE_CYCLES
) (
    input wire logic               clk,
    input wire logic               nrst,
    input wire ati_req_type        req,
    input wire logic               rvalid,
    input wire logic               cal_valid,
    input wire ati_trim_type [1:0] cal_trim,
    input wire ati_trim_type [1:0] trim,
    input wire logic               low_ac_det,
    input wire logic               corr_coarse_start,
    input wire logic               corr_apply,
    input wire logic               corr_upd_ofs,
    input wire logic               corr_upd_gain,
    input wire logic               corr_upd_skew,
    input wire logic               notch_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_read_answer: assert property (req.rd |=> rvalid)
        else $error("read got no answer one cycle later");
    a_no_stray_rvalid: assert property (!req.rd |=> !rvalid)
        else $error("answer without a read");
    a_cal_loads: assert property (cal_valid |=> trim == cal_trim)
        else $error("calibration words not loaded");
    a_trim_held: assert property (!cal_valid && !req.wr |=> $stable(trim))
        else $error("trim moved without a write or load");
    a_coarse_pulse: assert property (corr_coarse_start |=> !corr_coarse_start)
        else $error("coarse start longer than one cycle");
    a_upd_applies: assert property (corr_upd_ofs || corr_upd_gain || corr_upd_skew
        |-> corr_apply)
        else $error("update while corrections not applied");
    a_skew_low_ac: assert property (low_ac_det |=> !corr_upd_skew)
        else $error("skew updated under low AC power");
    a_notch_copy: assert property (req.wr && req.addr == ATI_ADDR_RUN_CTRL
        |=> ##1 notch_en == $past(req.wdata[ATI_NOTCH_BIT], 2))
        else $error("notch select does not follow control write");
endmodule : ati_regs_asserts

bind ati_regs ati_regs_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_ati_regs_asserts (
    .clk(clk), .nrst(nrst), .req(req), .rvalid(rvalid), .cal_valid(cal_valid),
    .cal_trim(cal_trim), .trim(trim), .low_ac_det(low_ac_det),
    .corr_coarse_start(corr_coarse_start), .corr_apply(corr_apply),
    .corr_upd_ofs(corr_upd_ofs), .corr_upd_gain(corr_upd_gain),
    .corr_upd_skew(corr_upd_skew), .notch_en(notch_en));

//--- ati_regs_bench.sv
// Self-checking bench for the trim and corrector register bank.
// Assumes the calibration model and the bound port checker.
`timescale 1ns/1ps
module ati_regs_bench;
    import ati_pkg::*;
    logic clk = 0, nrst = 0, cal_valid, low_pwr = 0, low_ac = 0, rvalid, coarse, apply;
    logic u_ofs, u_gain, u_skew, notch, gmo, on, seen_coarse = 0;
    logic [7:0] rdata, rv;
    ati_req_type req = '0;
    ati_trim_type [1:0] cal_trim, trim;
    ati_pmode_type pin = ATI_PM_SLEEP;
    ati_pmode_type [1:0] pmode;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    logic [2:0] codes[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    ati_pmode_type pexp[4] = '{ATI_PM_SLEEP, ATI_PM_NORMAL, ATI_PM_NAP, ATI_PM_SLEEP};

    ati_cal_model u_ati_cal_model (.clk(clk), .nrst(nrst), .cal_valid(cal_valid),
        .cal_trim(cal_trim));
    ati_regs #(.SETTLE_CYCLES(20)) u_ati_regs (.clk(clk), .nrst(nrst), .req(req),
        .rdata(rdata), .rvalid(rvalid), .cal_valid(cal_valid), .cal_trim(cal_trim),
        .power_mode_pin(pin), .low_power_det(low_pwr), .low_ac_det(low_ac), .trim(trim),
        .pmode(pmode), .corr_on(on), .corr_coarse_start(coarse), .corr_apply(apply),
        .corr_upd_ofs(u_ofs), .corr_upd_gain(u_gain), .corr_upd_skew(u_skew),
        .notch_en(notch), .gain_match_only(gmo));

    always #4 clk = ~clk;

    task automatic tally_and_finish;
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (coarse === 1'b1) seen_coarse <= 1'b1;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(negedge clk) req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(negedge clk) req <= '0;
        rv = rdata;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        cmp(rv, exp);
    endtask : rdc

    initial begin
        wait_n(16);
        nrst = 1'b1;
        wait_n(8);
        rdc(ATI_ADDR_OFS_BIG, ATI_BAD_INDEX);
        rdc(8'h40, ATI_UNMAPPED);
        wr(ATI_ADDR_INDEX, 8'h01);
        rdc(ATI_ADDR_OFS_BIG, 8'h11);
        rdc(ATI_ADDR_GAIN_SML, 8'h55);
        wr(ATI_ADDR_GAIN_BIG, 8'h0C);
        rdc(ATI_ADDR_GAIN_BIG, 8'h0C);
        rd(ATI_ADDR_OFS_SMALL);
        wr(ATI_ADDR_OFS_SMALL, rv + 8'h01);
        rdc(ATI_ADDR_OFS_SMALL, 8'h23);
        wr(ATI_ADDR_OFS_BIG, 8'h80);
        cmp(trim[0].ofs_big, 8'h80);
        wr(ATI_ADDR_INDEX, 8'h02);
        rdc(ATI_ADDR_OFS_BIG, 8'h99);
        wr(ATI_ADDR_INDEX, 8'h03);
        rdc(ATI_ADDR_OFS_BIG, ATI_BAD_INDEX);
        cmp(trim[0].ofs_big, 8'h80);
        wr(ATI_ADDR_INDEX, 8'h01);
        foreach (codes[i]) begin
            wr(ATI_ADDR_PD_SEL, {5'h00, codes[i]});
            wait_n(3);
            cmp({6'h00, pmode[0]}, {6'h00, pexp[i]});
        end
        pin = ATI_PM_NORMAL;
        wait_n(3);
        cmp({6'h00, pmode[0]}, {6'h00, ATI_PM_SLEEP});
        cmp({6'h00, pmode[1]}, {6'h00, ATI_PM_NORMAL});
        wr(ATI_ADDR_PORT_CFG, 8'h20);
        rdc(ATI_ADDR_PD_SEL, ATI_BAD_INDEX);
        rdc(ATI_ADDR_PORT_CFG, ATI_PORT_CFG_RST);
        wr(ATI_ADDR_INDEX, 8'h01);
        rdc(ATI_ADDR_PD_SEL, 8'h04);
        rdc(ATI_ADDR_OFS_SMALL, 8'h22);
        wr(ATI_ADDR_STAT_CTRL, 8'h20);
        wr(ATI_ADDR_RUN_CTRL, 8'h21);
        wait_n(4);
        cmp({6'h00, seen_coarse, gmo}, 8'h00);
        cmp({7'h00, notch}, 8'h01);
        rd(ATI_ADDR_STATUS);
        cmp({7'h00, rv[2]}, 8'h00);
        for (int k = 0; k < 60 && rv[2] !== 1'b1; k++) rd(ATI_ADDR_STATUS);
        cmp({7'h00, rv[2]}, 8'h01);
        cmp({7'h00, u_ofs}, 8'h01);
        wr(ATI_ADDR_RUN_CTRL, 8'h23);
        wait_n(3);
        cmp({7'h00, u_ofs}, 8'h00);
        wr(ATI_ADDR_RUN_CTRL, 8'h21);
        wait_n(3);
        rd(ATI_ADDR_STATUS);
        cmp({6'h00, u_ofs, rv[2]}, 8'h03);
        for (int j = 2; j < 5; j++) begin
            wr(ATI_ADDR_RUN_CTRL, 8'h01 | (8'h01 << j));
            wait_n(3);
            cmp({5'h00, u_skew, u_gain, u_ofs}, {5'h00, ~(3'h1 << (j - 2))});
        end
        wr(ATI_ADDR_RUN_CTRL, 8'h01);
        low_ac = 1'b1;
        wait_n(3);
        rd(ATI_ADDR_STATUS);
        cmp({5'h00, rv[1], u_gain, u_skew}, 8'h06);
        low_ac = 1'b0;
        low_pwr = 1'b1;
        wait_n(3);
        rd(ATI_ADDR_STATUS);
        cmp({5'h00, rv[0], apply, u_gain}, 8'h06);
        low_pwr = 1'b0;
        wr(ATI_ADDR_RUN_CTRL, 8'h00);
        wr(ATI_ADDR_STAT_CTRL, 8'h00);
        cmp({7'h00, on}, 8'h00);
        wr(ATI_ADDR_GAIN_MID, 8'h80);
        wr(ATI_ADDR_RUN_CTRL, 8'h01);
        wait_n(4);
        cmp({5'h00, on, seen_coarse, gmo}, 8'h07);
        rdc(ATI_ADDR_STATUS, 8'h00);
        tally_and_finish();
    end
endmodule : ati_regs_bench

//--- ati_settle_timer.sv
// Settling timer of the interleave corrector.
// Counts only while run is high, so a freeze or hold pauses it.
`timescale 1ns/1ps
module ati_settle_timer #(
    parameter int CYCLES = 1000
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic clear,
    input  wire logic run,
    output logic      done
);

    logic [31:0] count;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= 32'h0;
            done  <= 1'b0;
        end else if (clear) begin
            count <= 32'h0;
            done  <= 1'b0;
        end else if (run && !done) begin
            count <= count + 32'h1;
            done  <= (count == 32'(CYCLES - 1));
        end
    end

endmodule : ati_settle_timer
